/* rtl/erloe_pkg.sv */
/*
  Shared constants and types for the recall and output-enable block.
  Assumes a single 25 MHz system clock with a synchronous active-high reset.
*/
`default_nettype none

package erloe_pkg;

  // Timing
  localparam int CLK_FREQ_MHZ = 25;
  localparam int RECALL_TIME_US = 6000;
  localparam int RECALL_CYCLES_DFLT = RECALL_TIME_US * CLK_FREQ_MHZ;
  localparam int CNT_W = 18;

  // Control byte register
  localparam logic [7:0] CTRL_PTR_OFFSET = 8'h00;
  localparam logic [7:0] SOFT_RESET_CODE = 8'h06;

  // Bus framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [6:0] DEV_ADDR_DFLT = 7'h2a; // Arbitrary value

  // DAC channels
  localparam int NUM_GAMMA = 14;
  localparam logic [3:0] COMMON_CHANNEL = 4'he;
  localparam logic [3:0] LAST_CHANNEL = 4'he;

  // Factory default codes
  localparam logic [9:0] GAMMA_DEFAULT_CODE = 10'h000;
  localparam logic [9:0] COMMON_DEFAULT_CODE = 10'h200;

  typedef struct packed {
    logic valid;
    logic [3:0] channel;
    logic [9:0] code;
  } erloe_dac_wr_t;

  typedef struct packed {
    logic valid;
    logic [7:0] pointer;
    logic [7:0] data;
  } erloe_byte_wr_t;

  typedef enum logic [2:0] {
    I_IDLE = 3'b000,
    I_ADDR = 3'b001,
    I_ACK_ADDR = 3'b010,
    I_PTR = 3'b011,
    I_ACK_PTR = 3'b100,
    I_DATA = 3'b101,
    I_ACK_DATA = 3'b110,
    I_NACK = 3'b111
  } erloe_i2c_state_t;

  typedef enum logic [1:0] {
    RC_IDLE = 2'b00,
    RC_COPY = 2'b01,
    RC_WAIT = 2'b10
  } erloe_rc_state_t;

endpackage

`default_nettype wire

/* rtl/erloe_recall.sv */
/*
  Recall sequencer: copies every stored word into the DAC registers, then
  holds busy until the recall time has run out.
  Assumes the storage array answers combinationally to the registered address.
*/
`default_nettype none

module erloe_recall
  import erloe_pkg::*;
#(
  parameter logic [CNT_W-1:0] RECALL_CYCLES = CNT_W'(RECALL_CYCLES_DFLT)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Control
  input wire logic start,
  // Storage array
  input wire logic eeprom_blank,
  input wire logic [9:0] eeprom_rdata,
  output logic [3:0] eeprom_addr,
  // DAC register load
  output erloe_dac_wr_t dac_wr,
  // Status
  output logic busy,
  output logic done_pulse
);

  erloe_rc_state_t state;
  logic [CNT_W-1:0] cnt;

  wire logic [9:0] default_code = (eeprom_addr == COMMON_CHANNEL) ? COMMON_DEFAULT_CODE : GAMMA_DEFAULT_CODE;
  wire logic [9:0] load_code = eeprom_blank ? default_code : eeprom_rdata;
  wire logic time_up = (cnt == RECALL_CYCLES - CNT_W'(1));

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= RC_IDLE;
      cnt <= '0;
      eeprom_addr <= 4'h0;
      dac_wr <= '0;
      busy <= 1'b0;
      done_pulse <= 1'b0;
    end else begin
      dac_wr <= '0;
      done_pulse <= 1'b0;
      if (start) begin
        // A new trigger restarts the whole copy and timer
        state <= RC_COPY;
        cnt <= '0;
        eeprom_addr <= 4'h0;
        busy <= 1'b1;
      end else begin
        unique case (state)
          RC_IDLE: begin
            cnt <= '0;
          end
          RC_COPY: begin
            cnt <= cnt + CNT_W'(1);
            dac_wr <= '{valid: 1'b1, channel: eeprom_addr, code: load_code};
            if (eeprom_addr == LAST_CHANNEL) begin
              state <= RC_WAIT;
            end else begin
              eeprom_addr <= eeprom_addr + 4'h1;
            end
          end
          RC_WAIT: begin
            cnt <= cnt + CNT_W'(1);
            if (time_up) begin
              state <= RC_IDLE;
              busy <= 1'b0;
              done_pulse <= 1'b1;
            end
          end
          default: begin
            state <= RC_IDLE;
            busy <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

/* rtl/erloe_top.sv */
/*
  Recall and output-enable controller: two-wire bus slave that decodes the
  software-reset control byte, power-on recall trigger, supply lockout with
  hysteresis and thermal shutdown gating of the analog output drivers.
  Assumes bus pins and comparator flags are synchronous to clk, and that
  the supply and temperature comparators are provided by analog circuitry.
*/
`default_nettype none

//Contract
//- When logic supply comes up, copy all stored values into every DAC register.
//- A recall takes about six milliseconds, for power-on and software reset alike.
//- Writing 0x06 to pointer 0x00 starts recall at the eighth clock's falling edge.
//- The software-reset control byte is answered with a NACK on the ninth clock.
//- During any recall, outputs are high impedance and every bus command is NACKed.
//- At recall end, all gamma outputs and the common output enable together.
//- Factory defaults are code 0x000 for gamma channels and 0x200 for common.
//- At power-on, outputs stay disabled while analog supply is below lockout.
//- Gamma outputs enable only after recall and with analog supply above upper threshold.
//- Common output enables only when analog and amplifier supplies exceed upper threshold.
//- All outputs disable when analog supply falls below the lower threshold.
//- At the thermal shutdown point all outputs go to high impedance.
//- After shutdown, outputs re-enable once the die has cooled by the hysteresis.
module erloe_top
  import erloe_pkg::*;
#(
  parameter logic [CNT_W-1:0] RECALL_CYCLES = CNT_W'(RECALL_CYCLES_DFLT),
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DFLT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Two-wire bus
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Supply and temperature comparators
  input wire logic logic_supply_ok,
  input wire logic analog_above_upper,
  input wire logic analog_below_lower,
  input wire logic amplifier_supply_above_upper,
  input wire logic die_at_shutdown,
  input wire logic die_cooled,
  // Storage array
  input wire logic eeprom_blank,
  input wire logic [9:0] eeprom_rdata,
  output logic [3:0] eeprom_addr,
  // DAC register loads
  output erloe_dac_wr_t dac_wr,
  output erloe_byte_wr_t byte_wr,
  // Status and output drivers
  output logic recall_busy,
  output logic [NUM_GAMMA-1:0] gamma_outputs_enable,
  output logic common_voltage_output_enable
);

  function automatic logic is_rx_state(input erloe_i2c_state_t s);
    is_rx_state = (s == I_ADDR) || (s == I_PTR) || (s == I_DATA);
  endfunction

  function automatic logic is_ack_state(input erloe_i2c_state_t s);
    is_ack_state = (s == I_ACK_ADDR) || (s == I_ACK_PTR) || (s == I_ACK_DATA);
  endfunction

  // Bus sampling and edge detection
  logic scl_q;
  logic sda_q;
  erloe_i2c_state_t state;
  erloe_i2c_state_t next_state;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] pointer;

  wire logic scl_rise = scl && !scl_q;
  wire logic scl_fall = !scl && scl_q;
  wire logic start_cond = scl && scl_q && sda_q && !sda_in;
  wire logic stop_cond = scl && scl_q && !sda_q && sda_in;
  wire logic byte_done = is_rx_state(state) && scl_fall && (bitcnt == BITS_PER_BYTE);
  wire logic addr_match = (shreg[7:1] == DEV_ADDR) && !shreg[0];
  wire logic soft_reset_hit = (state == I_DATA) && byte_done && (pointer == CTRL_PTR_OFFSET)
    && (shreg == SOFT_RESET_CODE) && !recall_busy;
  wire logic ack_ok = !recall_busy && ((state != I_ADDR) || addr_match) && !soft_reset_hit;
  wire logic data_taken = (state == I_DATA) && byte_done && ack_ok;

  // Recall triggers
  logic logic_ok_q;
  logic recall_done;
  logic done_pulse;
  wire logic por_start = logic_supply_ok && !logic_ok_q;
  wire logic recall_start = por_start || soft_reset_hit;

  // Lockout and thermal state
  logic analog_ok;
  logic thermal_off;
  wire logic next_analog_ok = analog_below_lower ? 1'b0 : (analog_above_upper ? 1'b1 : analog_ok);
  wire logic next_thermal_off = die_at_shutdown ? 1'b1 : (die_cooled ? 1'b0 : thermal_off);
  wire logic next_recall_done = recall_start ? 1'b0 : (done_pulse ? 1'b1 : recall_done);
  wire logic next_gamma_en = next_recall_done && next_analog_ok && !next_thermal_off;
  wire logic next_common_en = next_gamma_en && amplifier_supply_above_upper;
  wire logic next_sda_oe_n = !is_ack_state(next_state);

  always_comb begin
    next_state = state;
    if (start_cond) begin
      next_state = I_ADDR;
    end else if (stop_cond) begin
      next_state = I_IDLE;
    end else begin
      unique case (state)
        I_IDLE: next_state = I_IDLE;
        I_ADDR: if (byte_done) next_state = ack_ok ? I_ACK_ADDR : I_NACK;
        I_PTR: if (byte_done) next_state = ack_ok ? I_ACK_PTR : I_NACK;
        I_DATA: if (byte_done) next_state = ack_ok ? I_ACK_DATA : I_NACK;
        I_ACK_ADDR: if (scl_fall) next_state = I_PTR;
        I_ACK_PTR: if (scl_fall) next_state = I_DATA;
        I_ACK_DATA: if (scl_fall) next_state = I_DATA;
        I_NACK: if (scl_fall) next_state = I_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      state <= I_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      pointer <= 8'h00;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
      byte_wr <= '0;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
      state <= next_state;
      sda_out <= 1'b0;
      sda_oe_n <= next_sda_oe_n;
      byte_wr <= '{valid: data_taken, pointer: pointer, data: shreg};
      if (start_cond || byte_done) begin
        bitcnt <= 4'h0;
      end else if (scl_rise && is_rx_state(state)) begin
        bitcnt <= bitcnt + 4'h1;
        shreg <= {shreg[6:0], sda_in};
      end
      if ((state == I_PTR) && byte_done && ack_ok) begin
        pointer <= shreg;
      end
    end
  end

  // Supply, thermal and enable registers
  always_ff @(posedge clk) begin
    if (srst) begin
      logic_ok_q <= 1'b0;
      recall_done <= 1'b0;
      analog_ok <= 1'b0;
      thermal_off <= 1'b0;
      gamma_outputs_enable <= '0;
      common_voltage_output_enable <= 1'b0;
    end else begin
      logic_ok_q <= logic_supply_ok;
      recall_done <= next_recall_done;
      analog_ok <= next_analog_ok;
      thermal_off <= next_thermal_off;
      gamma_outputs_enable <= {NUM_GAMMA{next_gamma_en}};
      common_voltage_output_enable <= next_common_en;
    end
  end

  erloe_recall #(
    .RECALL_CYCLES(RECALL_CYCLES)
  ) u_recall (
    .clk(clk),
    .srst(srst),
    .start(recall_start),
    .eeprom_blank(eeprom_blank),
    .eeprom_rdata(eeprom_rdata),
    .eeprom_addr(eeprom_addr),
    .dac_wr(dac_wr),
    .busy(recall_busy),
    .done_pulse(done_pulse)
  );

endmodule

`default_nettype wire

/* verification/erloe_host_model.sv */
/*
  Bus host and storage array model facing erloe_top.
  Assumes the bench drives on falling clk edges; the data line has a pull-up.
*/
`default_nettype none
module erloe_host_model
  import erloe_pkg::*;
(
  // Clock
  input wire logic clk,
  // Two-wire bus
  output logic scl,
  output logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // Storage array
  input wire logic [3:0] eeprom_addr,
  output logic [9:0] eeprom_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sda_drv = 1'b1;
  initial scl = 1'b1;
  // Pull-up, so a released line reads high
  assign sda_in = sda_drv & (sda_oe_n | sda_out);
  // Code differs per channel so misrouted loads show
  assign eeprom_rdata = {eeprom_addr, 6'h15};
  task automatic hp();
    repeat (4) @(negedge clk);
  endtask
  task automatic frame(input logic [7:0] ptr, input logic [7:0] dat, output logic [2:0] acks);
    logic [26:0] s;
    s = {DEV_ADDR_DFLT, 1'b0, 1'b1, ptr, 1'b1, dat, 1'b1};
    sda_drv = 1'b0;
    hp();
    scl = 1'b0;
    for (int i = 26; i >= 0; i--) begin
      sda_drv = s[i];
      hp();
      scl = 1'b1;
      hp();
      if (i % 9 == 0) acks[i / 9] = sda_in;
      scl = 1'b0;
    end
    sda_drv = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_drv = 1'b1;
    hp();
  endtask
endmodule
`default_nettype wire

/* verification/erloe_top_chk.sv */
/*
  Port checker for erloe_top.
  Assumes it is bound to every erloe_top instance by the statement below.
*/
`default_nettype none
module erloe_top_chk
  import erloe_pkg::*;
#(
  parameter logic [CNT_W-1:0] RECALL_CYCLES = CNT_W'(RECALL_CYCLES_DFLT)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Inputs
  input wire logic analog_below_lower,
  input wire logic amplifier_supply_above_upper,
  input wire logic die_at_shutdown,
  input wire logic eeprom_blank,
  // Outputs
  input wire logic sda_oe_n,
  input wire erloe_dac_wr_t dac_wr,
  input wire logic recall_busy,
  input wire logic [NUM_GAMMA-1:0] gamma_outputs_enable,
  input wire logic common_voltage_output_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [CNT_W-1:0] busy_cnt;
  wire logic all_off = gamma_outputs_enable == '0 && !common_voltage_output_enable;
  wire logic [9:0] exp_code = dac_wr.channel == COMMON_CHANNEL ? COMMON_DEFAULT_CODE : GAMMA_DEFAULT_CODE;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Length of the current busy run
  always_ff @(posedge clk) begin
    busy_cnt <= (srst || !recall_busy) ? '0 : busy_cnt + 1'b1;
  end
  a_busy_nack: assert property (recall_busy |-> sda_oe_n) else $error("ack in recall");
  a_busy_hiz: assert property (recall_busy |-> all_off) else $error("output on in recall");
  a_enable_together: assert property ((gamma_outputs_enable == '0 || &gamma_outputs_enable) &&
    (!common_voltage_output_enable || &gamma_outputs_enable)) else $error("enables split");
  a_lockout_off: assert property (analog_below_lower |=> all_off) else $error("on below lockout");
  a_thermal_off: assert property (die_at_shutdown |=> all_off) else $error("on when hot");
  a_amp_gate: assert property (!amplifier_supply_above_upper |=> !common_voltage_output_enable)
    else $error("common on without amp supply");
  a_busy_exact: assert property ($fell(recall_busy) && !$past(srst) |-> busy_cnt == RECALL_CYCLES)
    else $error("recall length");
  a_busy_bound: assert property (recall_busy |-> busy_cnt < RECALL_CYCLES) else $error("recall long");
  a_recall_loads: assert property ($rose(recall_busy) |=>
    (dac_wr.valid && dac_wr.channel == 4'h0) ##1 dac_wr.valid [*8]) else $error("recall loads");
  a_default_code: assert property (dac_wr.valid && eeprom_blank |-> dac_wr.code == exp_code)
    else $error("default code");
endmodule
bind erloe_top erloe_top_chk #(.RECALL_CYCLES(RECALL_CYCLES)) chk (.clk, .srst, .analog_below_lower,
  .amplifier_supply_above_upper, .die_at_shutdown, .eeprom_blank, .sda_oe_n, .dac_wr, .recall_busy,
  .gamma_outputs_enable, .common_voltage_output_enable);
`default_nettype wire

/* verification/test_eeprom_recall_output_enable.sv */
/*
  Self-checking bench for erloe_top with host and storage model.
  Assumes the checker binds itself; recall shortened to 600 cycles.
*/
`default_nettype none
module test_eeprom_recall_output_enable
  import erloe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [CNT_W-1:0] RC = CNT_W'(600);
  // Inputs per step: up, low, amp, hot, cool; then expected {common, gamma}
  localparam logic [19:0] STEPS [11] = '{
    {5'b01100, 15'h0}, {5'b10100, 15'h7fff}, {5'b00100, 15'h7fff}, {5'b01100, 15'h0},
    {5'b00100, 15'h0}, {5'b10100, 15'h7fff}, {5'b10000, 15'h3fff}, {5'b10110, 15'h0},
    {5'b10100, 15'h0}, {5'b10101, 15'h7fff}, {5'b10100, 15'h7fff}};
  logic clk = 1'b0, srst = 1'b1, blank = 1'b1, up = 1'b0, low = 1'b1, amp = 1'b1, hot = 1'b0, cool = 1'b0;
  logic lsup = 1'b0;
  logic scl, sda_in, sda_out, sda_oe_n, busy, cen;
  logic [15:0] wr_seen = 16'h0;
  logic [3:0] eaddr;
  logic [9:0] rdata;
  logic [9:0] codes [15];
  logic [NUM_GAMMA-1:0] gen;
  logic [2:0] acks;
  erloe_dac_wr_t dac_wr;
  erloe_byte_wr_t byte_wr;
  int nload, nwr, checks, bad_count, cyc;
  erloe_top #(.RECALL_CYCLES(RC)) dut (.clk, .srst, .scl, .sda_in, .sda_out, .sda_oe_n,
    .logic_supply_ok(lsup), .analog_above_upper(up), .analog_below_lower(low),
    .amplifier_supply_above_upper(amp), .die_at_shutdown(hot), .die_cooled(cool), .eeprom_blank(blank),
    .eeprom_rdata(rdata), .eeprom_addr(eaddr), .dac_wr, .byte_wr, .recall_busy(busy),
    .gamma_outputs_enable(gen), .common_voltage_output_enable(cen));
  erloe_host_model host (.clk, .scl, .sda_in, .sda_out, .sda_oe_n, .eeprom_addr(eaddr), .eeprom_rdata(rdata));
  initial forever #20 clk = ~clk;
  always @(negedge clk) begin
    cyc++;
    if (dac_wr.valid) begin
      codes[dac_wr.channel] = dac_wr.code;
      nload++;
    end
    // Acked data bytes as {pointer, data}
    if (byte_wr.valid) begin
      wr_seen = {byte_wr.pointer, byte_wr.data};
      nwr++;
    end
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic loads(input logic bl);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 700) begin
      @(negedge clk);
      n++;
    end
    check("busy", 16'h0, 16'(busy));
    check("loads", 16'd15, 16'(nload));
    for (int i = 0; i < 15; i++)
      check("code", bl ? (i == 14 ? 16'h200 : 16'h0) : 16'({4'(i), 6'h15}), 16'(codes[i]));
  endtask
  task automatic power_on();
    srst = 1'b0;
    repeat (2) @(negedge clk);
    check("busy", 16'h0, 16'(busy));
    lsup = 1'b1;
    repeat (2) @(negedge clk);
    check("busy", 16'h1, 16'(busy));
    loads(1'b1);
    for (int i = 0; i < 11; i++) begin
      {up, low, amp, hot, cool} = STEPS[i][19:15];
      repeat (2) @(negedge clk);
      check("enables", 16'(STEPS[i][14:0]), {1'b0, cen, gen});
    end
  endtask
  task automatic soft_reset();
    blank = 1'b0;
    nload = 0;
    host.frame(8'h00, 8'h06, acks);
    check("soft acks", 16'h1, 16'(acks));
    check("recall", 16'h2, {14'h0, busy, cen});
    host.frame(8'h05, 8'ha5, acks);
    check("busy acks", 16'h7, 16'(acks));
    loads(1'b0);
    // Enables register one cycle after busy drops
    @(negedge clk);
    check("enables", 16'h7fff, {1'b0, cen, gen});
    check("writes", 16'h0, 16'(nwr));
    host.frame(8'h05, 8'ha5, acks);
    check("write acks", 16'h0, 16'(acks));
    check("writes", 16'h1, 16'(nwr));
    check("byte write", 16'h05a5, wr_seen);
  endtask
  task automatic finish_test();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    power_on();
    soft_reset();
    finish_test();
  end
endmodule
`default_nettype wire
